// >>> dio_map.svh
// Register offsets, field positions, reset values and timing counts of the
// digital line control block.
// Assumes a 10 MHz clock and a byte-addressed register port of 32-bit words.
`ifndef DIO_MAP_SVH
`define DIO_MAP_SVH

// ============================================================================
// Register offsets
`define DIO_ADDR_LINE_SEL   8'h00
`define DIO_ADDR_LINE_CFG   8'h04
`define DIO_ADDR_FLT_SEL    8'h08
`define DIO_ADDR_FLT_WIDTH  8'h0C
`define DIO_ADDR_SNAPSHOT   8'h10
`define DIO_ADDR_USER_SEL   8'h14
`define DIO_ADDR_USER_VAL   8'h18
`define DIO_ADDR_USER_WORD  8'h1C

// ============================================================================
// Fields of the per-line configuration word
`define DIO_CFG_DIR_BIT     0
`define DIO_CFG_INV_BIT     1
`define DIO_CFG_SUP_BIT     2
`define DIO_CFG_SRC_LSB     8
`define DIO_CFG_SRC_W       5
`define DIO_CFG_FMT_LSB     16
`define DIO_CFG_LVL_BIT     24
`define DIO_WIDTH_W         16

// ============================================================================
// Per-line hardware facts and reset values
`define DIO_SUPPLY_CAP      4'h4
`define DIO_LINE_FORMATS    8'h25
`define DIO_RST_DIR         4'h0
`define DIO_RST_INV         4'h0
`define DIO_RST_USER        4'h0
`define DIO_RST_WIDTH       16'h0000

// ============================================================================
// Timing
`define DIO_CLK_PERIOD_NS   100
`define DIO_NS_PER_US       1000
`define DIO_CYC_PER_US      (`DIO_NS_PER_US / `DIO_CLK_PERIOD_NS)

`endif

// >>> dio_pkg.sv
// Types of the digital line control block.
// Assumes dio_map.svh supplies the numeric constants.
package dio_pkg;

    // ========================================================================
    // Output source codes
    typedef enum logic [4:0] {
        DIO_SRC_OFF   = 5'h00,
        DIO_SRC_LINE0 = 5'h01,
        DIO_SRC_LINE1 = 5'h02,
        DIO_SRC_LINE2 = 5'h03,
        DIO_SRC_LINE3 = 5'h04,
        DIO_SRC_USER0 = 5'h05,
        DIO_SRC_USER1 = 5'h06,
        DIO_SRC_USER2 = 5'h07,
        DIO_SRC_USER3 = 5'h08,
        DIO_SRC_CNT0  = 5'h09,
        DIO_SRC_CNT1  = 5'h0A,
        DIO_SRC_LB0   = 5'h0B,
        DIO_SRC_LB1   = 5'h0C,
        DIO_SRC_EXPO  = 5'h0D,
        DIO_SRC_FTW   = 5'h0E
    } dio_src_type;

    typedef enum logic {
        DIO_FLT_DEGLITCH = 1'b0,
        DIO_FLT_DEBOUNCE = 1'b1
    } dio_fkind_type;

    typedef enum logic [1:0] {
        DIO_FMT_TRISTATE  = 2'h0,
        DIO_FMT_OPTO      = 2'h1,
        DIO_FMT_OPENDRAIN = 2'h2
    } dio_fmt_type;

    // ========================================================================
    // State of the control module
    typedef struct packed {
        logic [1:0]             lineSel;
        logic [3:0]             dir;
        logic [3:0]             inv;
        logic [3:0]             supply;
        dio_src_type [3:0]      src;
        dio_fkind_type          fltSel;
        logic [3:0][15:0]       dgWidth;
        logic [3:0][15:0]       dbWidth;
        logic [1:0]             userSel;
        logic [3:0]             user;
        logic [3:0]             sync1;
        logic [3:0]             sync2;
        logic [3:0]             sync3;
        logic [3:0]             pin;
        logic [3:0]             level;
        logic [3:0]             drive;
        logic [3:0]             oeN;
        logic [3:0]             supplyOut;
        logic [31:0]            rdData;
    } dio_state_type;

    // State of one line's filter chain
    typedef struct packed {
        logic                   dgOut;
        logic [19:0]            dgCnt;
        logic                   dbOut;
        logic                   busy;
        logic [19:0]            dbCnt;
    } dio_flt_type;

endpackage

// >>> dio_filt_if.sv
// Carrier between the line control module and its input filter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface dio_filt_if;
    logic             ce;
    logic [3:0]       raw;
    logic [3:0][15:0] dgWidth;
    logic [3:0][15:0] dbWidth;
    logic [3:0]       filtered;

    modport ctrl (output ce, output raw, output dgWidth, output dbWidth,
                  input filtered);
    modport filt (input ce, input raw, input dgWidth, input dbWidth,
                  output filtered);
endinterface

// >>> dio_input_filter.sv
// Deglitch followed by debounce for each of the four input lines.
// Assumes raw levels are already synchronised to clk.
`timescale 1ns/100ps
`include "dio_map.svh"
module dio_input_filter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Filter carrier
    dio_filt_if.filt fi
);

    dio_pkg::dio_flt_type [3:0] st;
    dio_pkg::dio_flt_type [3:0] next_st;
    logic [3:0][19:0]           dgT;
    logic [3:0][19:0]           dbT;

    // ========================================================================
    // Next state
    always_comb begin
        next_st = st;
        for (int i = 0; i < 4; i++) begin
            dgT[i] = 20'(fi.dgWidth[i]) * 20'(`DIO_CYC_PER_US);
            dbT[i] = 20'(fi.dbWidth[i]) * 20'(`DIO_CYC_PER_US);
        end
        if (!rst_n) begin
            next_st = '0;
        end else if (fi.ce) begin
            for (int i = 0; i < 4; i++) begin
                if (fi.raw[i] != st[i].dgOut) begin
                    if (st[i].dgCnt + 20'h1 >= dgT[i]) begin
                        next_st[i].dgOut = fi.raw[i];
                        next_st[i].dgCnt = 20'h0;
                    end else begin
                        next_st[i].dgCnt = st[i].dgCnt + 20'h1;
                    end
                end else begin
                    next_st[i].dgCnt = 20'h0;
                end
                if (st[i].busy) begin
                    if (st[i].dbCnt + 20'h1 >= dbT[i]) begin
                        next_st[i].busy  = 1'b0;
                        next_st[i].dbCnt = 20'h0;
                    end else begin
                        next_st[i].dbCnt = st[i].dbCnt + 20'h1;
                    end
                end else if (st[i].dgOut != st[i].dbOut) begin
                    next_st[i].dbOut = st[i].dgOut;
                    next_st[i].busy  = (dbT[i] != 20'h0);
                    next_st[i].dbCnt = 20'h0;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // ========================================================================
    // Outputs and checks per line
    for (genvar g = 0; g < 4; g++) begin : gLine
        assign fi.filtered[g] = st[g].dbOut;

        property p_deglitch_hold;
            @(posedge clk) disable iff (!rst_n)
            fi.ce && (fi.raw[g] != st[g].dgOut)
                && (st[g].dgCnt + 20'h1 < dgT[g])
                |=> st[g].dgOut == $past(st[g].dgOut);
        endproperty
        a_deglitch_hold: assert property (p_deglitch_hold)
            else $error("deglitch output moved before width elapsed");

        property p_debounce_lock;
            @(posedge clk) disable iff (!rst_n)
            fi.ce && st[g].busy |=> st[g].dbOut == $past(st[g].dbOut);
        endproperty
        a_debounce_lock: assert property (p_debounce_lock)
            else $error("debounce output changed during lockout");

        property p_chain_order;
            @(posedge clk) disable iff (!rst_n)
            fi.ce && !st[g].busy && (st[g].dgOut != st[g].dbOut)
                |=> st[g].dbOut == $past(st[g].dgOut);
        endproperty
        a_chain_order: assert property (p_chain_order)
            else $error("debounce did not take first deglitched edge");
    end

endmodule // dio_input_filter

// >>> dio_line_ctrl.sv
// Control of four general purpose lines: direction, inversion, filtering,
// output source selection, user output bits and level readback.
// Assumes a 10 MHz clk, a register master that meets the strobe timing,
// and source signals that come from logic on the same clock.
//
// Behaviour
// - Four lines exist and software picks which one to configure by index.
// - Each line stores its own direction, input or output.
// - Each line has an inversion control acting on its signal.
// - Reading the selected line's level gives its logic state in any mode.
// - A read-only word shows all four line levels, bit n for line n.
// - Each line keeps deglitch and debounce widths in microseconds.
// - Deglitch accepts a new level only after it persisted the width.
// - Debounce passes the first edge and locks further change for the width.
// - The deglitch result feeds the debounce filter.
// - Each line's source selection acts only while it is an output.
// - Sources are lines, user bits, counters, logic blocks, exposure, wait.
// - A user bit selector and value control set one user output bit.
// - A user output word writes and reads all user bits together.
// - A read-only format field reports each line's circuit type.
// - Only capable lines offer the supply output enable.
`timescale 1ns/100ps
`include "dio_map.svh"
module dio_line_ctrl (
    // Clock, reset, enable
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wrData,
    input  wire logic        wrEn,
    input  wire logic        rdEn,
    output logic      [31:0] rdData,
    // Connector lines
    input  wire logic [3:0]  lineIn,
    output logic      [3:0]  lineOut,
    output logic      [3:0]  lineOe_n,
    output logic      [3:0]  supplyEn,
    // Internal sources
    input  wire logic [1:0]  counterActive,
    input  wire logic [1:0]  logicBlock,
    input  wire logic        exposureActive,
    input  wire logic        frameTriggerWait,
    // User output bits
    output logic      [3:0]  userOutput
);

    dio_pkg::dio_state_type st;
    dio_pkg::dio_state_type next_st;
    dio_filt_if             fi ();
    logic [3:0]             srcVal;
    logic [31:0]            cfgWord;
    logic [7:0]             formats;
    logic [3:0]             supplyCap;

    // ========================================================================
    // Filter chain
    assign fi.ce      = ce;
    assign fi.raw     = st.pin;
    assign fi.dgWidth = st.dgWidth;
    assign fi.dbWidth = st.dbWidth;
    assign formats    = `DIO_LINE_FORMATS;
    assign supplyCap  = `DIO_SUPPLY_CAP;

    dio_input_filter uFilter (
        .clk   (clk),
        .rst_n (rst_n),
        .fi    (fi.filt)
    );

    // ========================================================================
    // Source multiplexer
    function automatic logic src_value(
        input dio_pkg::dio_src_type s,
        input logic [3:0]           lvl,
        input logic [3:0]           usr,
        input logic [1:0]           cnt,
        input logic [1:0]           lb,
        input logic                 expo,
        input logic                 ftw
    );
        logic v;
        v = 1'b0;
        case (s)
            dio_pkg::DIO_SRC_LINE0: v = lvl[0];
            dio_pkg::DIO_SRC_LINE1: v = lvl[1];
            dio_pkg::DIO_SRC_LINE2: v = lvl[2];
            dio_pkg::DIO_SRC_LINE3: v = lvl[3];
            dio_pkg::DIO_SRC_USER0: v = usr[0];
            dio_pkg::DIO_SRC_USER1: v = usr[1];
            dio_pkg::DIO_SRC_USER2: v = usr[2];
            dio_pkg::DIO_SRC_USER3: v = usr[3];
            dio_pkg::DIO_SRC_CNT0:  v = cnt[0];
            dio_pkg::DIO_SRC_CNT1:  v = cnt[1];
            dio_pkg::DIO_SRC_LB0:   v = lb[0];
            dio_pkg::DIO_SRC_LB1:   v = lb[1];
            dio_pkg::DIO_SRC_EXPO:  v = expo;
            dio_pkg::DIO_SRC_FTW:   v = ftw;
            default:                v = 1'b0;
        endcase
        return v;
    endfunction

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            srcVal[i] = src_value(st.src[i], st.level, st.user,
                                  counterActive, logicBlock,
                                  exposureActive, frameTriggerWait);
        end
    end

    // Configuration word of the selected line
    always_comb begin
        cfgWord = 32'h0;
        cfgWord[`DIO_CFG_DIR_BIT] = st.dir[st.lineSel];
        cfgWord[`DIO_CFG_INV_BIT] = st.inv[st.lineSel];
        cfgWord[`DIO_CFG_SUP_BIT] = st.supply[st.lineSel];
        cfgWord[`DIO_CFG_SRC_LSB +: `DIO_CFG_SRC_W] = st.src[st.lineSel];
        cfgWord[`DIO_CFG_FMT_LSB +: 2] = formats[2 * st.lineSel +: 2];
        cfgWord[`DIO_CFG_LVL_BIT] = st.level[st.lineSel];
    end

    // ========================================================================
    // Next state
    always_comb begin
        next_st = st;
        if (!rst_n) begin
            next_st         = '0;
            next_st.dir     = `DIO_RST_DIR;
            next_st.inv     = `DIO_RST_INV;
            next_st.user    = `DIO_RST_USER;
            next_st.oeN     = 4'hF;
            for (int i = 0; i < 4; i++) begin
                next_st.src[i]     = dio_pkg::DIO_SRC_OFF;
                next_st.dgWidth[i] = `DIO_RST_WIDTH;
                next_st.dbWidth[i] = `DIO_RST_WIDTH;
            end
        end else if (ce) begin
            // Pin synchroniser: accept when stages two and three agree
            next_st.sync1 = lineIn;
            next_st.sync2 = st.sync1;
            next_st.sync3 = st.sync2;
            for (int i = 0; i < 4; i++) begin
                if (st.sync2[i] == st.sync3[i]) begin
                    next_st.pin[i] = st.sync3[i];
                end
                if (st.dir[i]) begin
                    next_st.drive[i] = srcVal[i] ^ st.inv[i];
                    next_st.level[i] = srcVal[i] ^ st.inv[i];
                end else begin
                    next_st.drive[i] = 1'b0;
                    next_st.level[i] = fi.filtered[i] ^ st.inv[i];
                end
            end
            next_st.oeN       = ~st.dir;
            next_st.supplyOut = st.supply & `DIO_SUPPLY_CAP;

            // Register reads: data stand until the next cycle with ce high
            next_st.rdData = 32'h0;
            if (rdEn) begin
                case (addr)
                    `DIO_ADDR_LINE_SEL:
                        next_st.rdData = {30'h0, st.lineSel};
                    `DIO_ADDR_LINE_CFG:
                        next_st.rdData = cfgWord;
                    `DIO_ADDR_FLT_SEL:
                        next_st.rdData = {31'h0, st.fltSel};
                    `DIO_ADDR_FLT_WIDTH:
                        next_st.rdData =
                            (st.fltSel == dio_pkg::DIO_FLT_DEBOUNCE)
                            ? {16'h0, st.dbWidth[st.lineSel]}
                            : {16'h0, st.dgWidth[st.lineSel]};
                    // snapshot of all levels, one sample
                    // a polled copy, not a real-time view
                    `DIO_ADDR_SNAPSHOT:
                        next_st.rdData = {28'h0, st.level};
                    `DIO_ADDR_USER_SEL:
                        next_st.rdData = {30'h0, st.userSel};
                    `DIO_ADDR_USER_VAL:
                        next_st.rdData = {31'h0, st.user[st.userSel]};
                    `DIO_ADDR_USER_WORD:
                        next_st.rdData = {28'h0, st.user};
                    default:
                        next_st.rdData = 32'h0;
                endcase
            end

            // Register writes
            if (wrEn) begin
                case (addr)
                    `DIO_ADDR_LINE_SEL:
                        next_st.lineSel = wrData[1:0];
                    `DIO_ADDR_LINE_CFG: begin
                        next_st.dir[st.lineSel] = wrData[`DIO_CFG_DIR_BIT];
                        next_st.inv[st.lineSel] = wrData[`DIO_CFG_INV_BIT];
                        next_st.supply[st.lineSel] =
                            wrData[`DIO_CFG_SUP_BIT]
                            & supplyCap[st.lineSel];
                        next_st.src[st.lineSel] = dio_pkg::dio_src_type'(
                            wrData[`DIO_CFG_SRC_LSB +: `DIO_CFG_SRC_W]);
                    end
                    `DIO_ADDR_FLT_SEL:
                        next_st.fltSel = dio_pkg::dio_fkind_type'(wrData[0]);
                    // width per line and filter kind
                    `DIO_ADDR_FLT_WIDTH: begin
                        if (st.fltSel == dio_pkg::DIO_FLT_DEBOUNCE) begin
                            next_st.dbWidth[st.lineSel] =
                                wrData[`DIO_WIDTH_W-1:0];
                        end else begin
                            next_st.dgWidth[st.lineSel] =
                                wrData[`DIO_WIDTH_W-1:0];
                        end
                    end
                    `DIO_ADDR_USER_SEL:
                        next_st.userSel = wrData[1:0];
                    `DIO_ADDR_USER_VAL:
                        next_st.user[st.userSel] = wrData[0];
                    `DIO_ADDR_USER_WORD:
                        next_st.user = wrData[3:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    // ========================================================================
    // Outputs
    assign rdData     = st.rdData;
    assign lineOut    = st.drive;
    assign lineOe_n   = st.oeN;
    assign supplyEn   = st.supplyOut;
    assign userOutput = st.user;

    // ========================================================================
    // Checks
    property p_dir_enable;
        @(posedge clk) disable iff (!rst_n)
        ce |=> lineOe_n == ~$past(st.dir);
    endproperty
    a_dir_enable: assert property (p_dir_enable)
        else $error("output enable does not follow direction");

    property p_user_drive;
        @(posedge clk) disable iff (!rst_n)
        ce && st.dir[0] && (st.src[0] == dio_pkg::DIO_SRC_USER1)
            |=> lineOut[0] == ($past(st.user[1]) ^ $past(st.inv[0]));
    endproperty
    a_user_drive: assert property (p_user_drive)
        else $error("line 0 does not drive inverted user bit 1");

    property p_input_level;
        @(posedge clk) disable iff (!rst_n)
        ce && !st.dir[3]
            |=> st.level[3] == ($past(fi.filtered[3]) ^ $past(st.inv[3]));
    endproperty
    a_input_level: assert property (p_input_level)
        else $error("input level is not the inverted filtered pin");

    property p_snapshot;
        @(posedge clk) disable iff (!rst_n)
        ce && rdEn && (addr == `DIO_ADDR_SNAPSHOT)
            |=> (rdData == {28'h0, $past(st.level)})
            ##1 (rdData == 32'h0 || $past(rdEn) || !$past(ce));
    endproperty
    a_snapshot: assert property (p_snapshot)
        else $error("snapshot read returned wrong levels");

    property p_user_word;
        @(posedge clk) disable iff (!rst_n)
        ce && wrEn && (addr == `DIO_ADDR_USER_WORD)
            |=> userOutput == $past(wrData[3:0]);
    endproperty
    a_user_word: assert property (p_user_word)
        else $error("user word write not applied to all bits");

    property p_user_bit;
        @(posedge clk) disable iff (!rst_n)
        ce && wrEn && (addr == `DIO_ADDR_USER_VAL)
            |=> userOutput[$past(st.userSel)] == $past(wrData[0]);
    endproperty
    a_user_bit: assert property (p_user_bit)
        else $error("selected user bit not written");

    property p_supply_cap;
        @(posedge clk) disable iff (!rst_n)
        (supplyEn & ~`DIO_SUPPLY_CAP) == 4'h0;
    endproperty
    a_supply_cap: assert property (p_supply_cap)
        else $error("supply enabled on an incapable line");

    property p_line_select;
        @(posedge clk) disable iff (!rst_n)
        ce && wrEn && (addr == `DIO_ADDR_LINE_SEL)
            |=> st.lineSel == $past(wrData[1:0]);
    endproperty
    a_line_select: assert property (p_line_select)
        else $error("line selector write not applied");

    property p_supply_refused;
        @(posedge clk) disable iff (!rst_n)
        ce && wrEn && (addr == `DIO_ADDR_LINE_CFG) && !supplyCap[st.lineSel]
            |=> st.supply == $past(st.supply);
    endproperty
    a_supply_refused: assert property (p_supply_refused)
        else $error("supply enable taken on an incapable line");

    property p_filter_width;
        @(posedge clk) disable iff (!rst_n)
        ce && wrEn && (addr == `DIO_ADDR_FLT_WIDTH)
            && (st.fltSel == dio_pkg::DIO_FLT_DEBOUNCE)
            |=> st.dbWidth[$past(st.lineSel)] == $past(wrData[15:0]);
    endproperty
    a_filter_width: assert property (p_filter_width)
        else $error("debounce width not stored for selected line");

    property p_input_no_drive;
        @(posedge clk) disable iff (!rst_n)
        ce && !st.dir[1] |=> lineOut[1] == 1'b0;
    endproperty
    a_input_no_drive: assert property (p_input_no_drive)
        else $error("input line 1 is driven");

    property p_reset_defaults;
        @(posedge clk) disable iff (1'b0)
        !rst_n |=> (st.dir == 4'h0) && (st.inv == 4'h0)
            && (userOutput == 4'h0) && (lineOe_n == 4'hF);
    endproperty
    a_reset_defaults: assert property (p_reset_defaults)
        else $error("reset did not restore line defaults");

endmodule // dio_line_ctrl

// >>> dio_line_ext.sv
// External circuits wired to the four connector lines.
// Assumes the bench sets extLevel; a driven line shows the block's value.
`timescale 1ns/100ps
module dio_line_ext (
    // Line side
    input  wire logic [3:0] lineOut,
    input  wire logic [3:0] lineOe_n,
    input  wire logic [3:0] extLevel,
    output logic      [3:0] lineIn
);
    // ========================================================================
    // Wire resolution
    // levels held long, never polled
    assign lineIn = (lineOe_n & extLevel) | (~lineOe_n & lineOut);
endmodule // dio_line_ext

// >>> dio_line_ctrl_test.sv
// Self-checking bench of the digital line control block.
// Assumes dio_line_ext stands for the circuits on the connector.
`timescale 1ns/100ps
`include "dio_map.svh"
module dio_line_ctrl_test;
    logic        clk = 1'b0, rst_n = 1'b0, wrEn = 1'b0, rdEn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wrData = 32'h0, rdData, d;
    logic [3:0]  lineIn, lineOut, lineOe_n, supplyEn, userOutput;
    logic [3:0]  ext = 4'h0;
    logic [1:0]  cnt = 2'h1, lb = 2'h2;
    logic        expo = 1'b1, ftw = 1'b0, ce = 1'b1;
    int          miscompares = 0, checks = 0, cycles = 0;

    always #50 clk = ~clk;

    dio_line_ctrl DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr),
        .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
        .lineIn(lineIn), .lineOut(lineOut), .lineOe_n(lineOe_n),
        .supplyEn(supplyEn), .counterActive(cnt), .logicBlock(lb),
        .exposureActive(expo), .frameTriggerWait(ftw),
        .userOutput(userOutput));
    dio_line_ext EXT (.lineOut(lineOut), .lineOe_n(lineOe_n),
        .extLevel(ext), .lineIn(lineIn));

    // ========================================================================
    // Shared tasks
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge clk);
        addr   <= a;
        wrData <= v;
        wrEn   <= 1'b1;
        @(posedge clk);
        wrEn   <= 1'b0;
        #1;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rdEn <= 1'b1;
        @(posedge clk);
        rdEn <= 1'b0;
        #1 d = rdData;
    endtask
    task automatic idle(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic drive(logic [3:0] v);
        @(posedge clk);
        ext <= v;
    endtask

    // ========================================================================
    // Scenarios
    // reset values, formats
    task automatic t_reset();
        dio_pkg::dio_fmt_type fmt [4];
        fmt = '{dio_pkg::DIO_FMT_OPTO, dio_pkg::DIO_FMT_OPTO,
                dio_pkg::DIO_FMT_OPENDRAIN, dio_pkg::DIO_FMT_TRISTATE};
        chk("oe_n", lineOe_n, 32'hF);
        chk("userOut", userOutput, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(`DIO_ADDR_LINE_SEL, 32'(i));
            rd(`DIO_ADDR_LINE_CFG);
            chk("cfg", d & 32'h0103_1F07, {14'h0, fmt[i], 16'h0});
        end
    endtask
    task automatic t_user();
        wr(`DIO_ADDR_USER_WORD, 32'h5);
        chk("userOut", userOutput, 32'h5);
        @(posedge clk);
        ce <= 1'b0;
        wr(`DIO_ADDR_USER_WORD, 32'hA);
        chk("frozen", userOutput, 32'h5);
        @(posedge clk);
        ce <= 1'b1;
        wr(`DIO_ADDR_USER_SEL, 32'h3);
        wr(`DIO_ADDR_USER_VAL, 32'h1);
        rd(`DIO_ADDR_USER_WORD);
        chk("userWord", d, 32'hD);
        wr(`DIO_ADDR_USER_VAL, 32'h0);
        chk("userOut", userOutput, 32'h5);
        rd(8'h40);
        chk("unmapped", d, 32'h0);
    endtask
    task automatic t_input();
        drive(4'hA);
        idle(12);
        rd(`DIO_ADDR_SNAPSHOT);
        chk("snapshot", d, 32'hA);
        wr(`DIO_ADDR_LINE_SEL, 32'h1);
        rd(`DIO_ADDR_LINE_CFG);
        chk("level1", d[24], 32'h1);
        wr(`DIO_ADDR_LINE_SEL, 32'h0);
        wr(`DIO_ADDR_LINE_CFG, 32'h2);
        idle(4);
        rd(`DIO_ADDR_SNAPSHOT);
        chk("inverted", d, 32'hB);
        wr(`DIO_ADDR_LINE_CFG, 32'h0);
    endtask
    // deglitch on line 1, debounce on line 3
    task automatic t_filter();
        drive(4'h0);
        wr(`DIO_ADDR_LINE_SEL, 32'h1);
        wr(`DIO_ADDR_FLT_WIDTH, 32'h1);
        idle(20);
        drive(4'h2);
        idle(5);
        drive(4'h0);
        idle(15);
        rd(`DIO_ADDR_SNAPSHOT);
        chk("glitch", d, 32'h0);
        drive(4'h2);
        idle(8);
        rd(`DIO_ADDR_SNAPSHOT);
        chk("delayed", d, 32'h0);
        idle(10);
        rd(`DIO_ADDR_SNAPSHOT);
        chk("accepted", d, 32'h2);
        wr(`DIO_ADDR_LINE_SEL, 32'h3);
        wr(`DIO_ADDR_FLT_SEL, 32'h1);
        wr(`DIO_ADDR_FLT_WIDTH, 32'h2);
        drive(4'hA);
        idle(8);
        rd(`DIO_ADDR_SNAPSHOT);
        chk("firstEdge", d, 32'hA);
        drive(4'h2);
        idle(6);
        rd(`DIO_ADDR_SNAPSHOT);
        chk("locked", d, 32'hA);
        idle(30);
        rd(`DIO_ADDR_SNAPSHOT);
        chk("released", d, 32'h2);
    endtask
    task automatic t_output();
        logic [15:0] tbl;
        tbl = 16'h32B2;
        drive(4'h9);
        idle(30);
        wr(`DIO_ADDR_LINE_SEL, 32'h2);
        wr(`DIO_ADDR_LINE_CFG, 32'h0500);
        idle(3);
        chk("inputOe", lineOe_n, 32'hF);
        chk("inputOut", lineOut, 32'h0);
        for (int c = 0; c < 16; c++) begin
            if (c == 3) continue;
            wr(`DIO_ADDR_LINE_CFG, {19'h0, 5'(c), 8'h05});
            idle(12);
            rd(`DIO_ADDR_LINE_CFG);
            chk("drive", lineOut[2], tbl[c]);
            chk("level2", d[24], tbl[c]);
        end
        chk("oe", lineOe_n, 32'hB);
        chk("supply", supplyEn, 32'h4);
        wr(`DIO_ADDR_LINE_SEL, 32'h0);
        wr(`DIO_ADDR_LINE_CFG, 32'h4);
        rd(`DIO_ADDR_LINE_CFG);
        chk("noSupply", d[2], 32'h0);
        wr(`DIO_ADDR_LINE_CFG, 32'h0603);
        idle(3);
        chk("outInvert", lineOut[0], 32'h1);
    endtask

    // ========================================================================
    // Run control
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        t_reset();
        t_user();
        t_input();
        t_filter();
        t_output();
        report_and_stop();
    end
endmodule // dio_line_ctrl_test
